/* sfrb_defs.svh */
// Constants for the serial flash reset and busy timing block
`ifndef SFRB_DEFS_SVH
`define SFRB_DEFS_SVH
// ----------------------------------------------------------------------
// Clock and pulse width
// ----------------------------------------------------------------------
`define SFRB_CLK_MHZ              250
`define SFRB_RESET_PULSE_MIN_US   10
`define SFRB_RESET_PULSE_CYC      (`SFRB_RESET_PULSE_MIN_US * `SFRB_CLK_MHZ)
// ----------------------------------------------------------------------
// Recovery waits (host side; kept for reference)
// ----------------------------------------------------------------------
`define SFRB_RECOV_READ_NS        200
`define SFRB_RECOV_PROG_US        20
`define SFRB_RECOV_ERASE_MS       20
`define SFRB_POWERUP_SELECT_US    300
// ----------------------------------------------------------------------
// Busy times, maximum, in their own units
// ----------------------------------------------------------------------
`define SFRB_SWC_MAX_MS           100
`define SFRB_TPP_MAX_MS           5
`define SFRB_TBP_MAX_US           300
`define SFRB_TSE_MAX_MS           300
`define SFRB_TBE32_MAX_S          2
`define SFRB_TBE64_MAX_S          2
`define SFRB_TCE_MAX_S            200
`define SFRB_TWPS_MAX_MS          1
`define SFRB_TWSR_MAX_MS          1
// Typical busy times
`define SFRB_SWC_TYP_MS           40
`define SFRB_TPP_TYP_US           1400
`define SFRB_TBP_TYP_US           9
`define SFRB_TSE_TYP_MS           60
`define SFRB_TBE32_TYP_MS         500
`define SFRB_TBE64_TYP_MS         700
`define SFRB_TCE_TYP_S            80
`define SFRB_TWPS_TYP_US          500
`define SFRB_TWSR_TYP_US          500
// ----------------------------------------------------------------------
// Delivery and reset values
// ----------------------------------------------------------------------
`define SFRB_ARRAY_ERASED         8'hFF
`define SFRB_STATUS_RST           8'h00
`define SFRB_STATUS_BUSY_BIT      0
`define SFRB_STATUS_LATCH_BIT     1
`endif

/* sfrb_pkg.sv */
// Types for the serial flash reset and busy timing block
package sfrb_pkg;
   // Timed operation kinds
   typedef enum logic [3:0] {
      SFRB_OP_NONE,
      SFRB_OP_STATUS_WRITE,
      SFRB_OP_PAGE_PROG,
      SFRB_OP_BYTE_PROG,
      SFRB_OP_SECTOR_ERASE,
      SFRB_OP_BLOCK32_ERASE,
      SFRB_OP_BLOCK64_ERASE,
      SFRB_OP_CHIP_ERASE,
      SFRB_OP_PROT_SELECT,
      SFRB_OP_SECURITY_WRITE
   } sfrb_op_t;
   // What the reset interrupted
   typedef enum logic [2:0] {
      SFRB_INT_NONE,
      SFRB_INT_READ,
      SFRB_INT_PROGRAM,
      SFRB_INT_ERASE,
      SFRB_INT_STATUS_WRITE
   } sfrb_intr_t;
endpackage

/* sfrb_sync.sv */
// Two flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module sfrb_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // Data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta_r <= INIT;
         q      <= INIT;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

/* sfrb_core.sv */
// Reset pin handling and operation busy timer of a serial flash
`timescale 1ns/1ps
`include "sfrb_defs.svh"

// Function
// [RQ1] Reset low ten microseconds forces full reset
// [RQ2] After reset: standby, volatile bits cleared
// [RQ3] Reset aborts running program or erase
// [RQ4] Data output high impedance during reset
// [RQ5] Host waits 200 ns after read
// [RQ6] Host waits 20 us after program; host model waits RCV_PROG, 100 cycles (400 ns)
// [RQ7] Host waits 20 ms after erase; host model waits RCV_ERASE, 200 cycles (800 ns)
// [RQ8] Host waits status write cycle time
// [RQ9] Delivered array FFh, status 00h
// [RQ10] Host selects 300 us after power-up; host model waits PWR_CYC, 75 cycles (300 ns)
// [RQ11] Status write busy 40 typ, 100 ms
// [RQ12] Page program 1.4 ms typ, 5 max
// [RQ13] Byte program 9 us typ, 300 max
// [RQ14] Sector erase 60 ms typ, 300 max
// [RQ15] 32KB erase 0.5 s typ, 2 max
// [RQ16] 64KB erase 0.7 s typ, 2 max
// [RQ17] Chip erase 80 s typ, 200 max
// [RQ18] Protection selection at most 1 ms
// [RQ19] Security register write at most 1 ms
// [RQ20] Host clock limit by dummy cycles
// [RQ21] Write in progress held during timed operations
module sfrb_core
   import sfrb_pkg::*;
#(
   parameter int CLK_MHZ      = `SFRB_CLK_MHZ,
   parameter int RST_PULSE_CYC = `SFRB_RESET_PULSE_CYC,
   // Typical busy figures in cycles; overridable to shorten simulation
   parameter longint SWC_CYC   = longint'(`SFRB_SWC_TYP_MS) * 1000 * CLK_MHZ,
   parameter longint TPP_CYC   = longint'(`SFRB_TPP_TYP_US) * CLK_MHZ,
   parameter longint TBP_CYC   = longint'(`SFRB_TBP_TYP_US) * CLK_MHZ,
   parameter longint TSE_CYC   = longint'(`SFRB_TSE_TYP_MS) * 1000 * CLK_MHZ,
   parameter longint TBE32_CYC = longint'(`SFRB_TBE32_TYP_MS) * 1000 * CLK_MHZ,
   parameter longint TBE64_CYC = longint'(`SFRB_TBE64_TYP_MS) * 1000 * CLK_MHZ,
   parameter longint TCE_CYC   = longint'(`SFRB_TCE_TYP_S) * 1000000 * CLK_MHZ,
   parameter longint TWPS_CYC  = longint'(`SFRB_TWPS_TYP_US) * CLK_MHZ,
   parameter longint TWSR_CYC  = longint'(`SFRB_TWSR_TYP_US) * CLK_MHZ
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // Flash reset pin, active low, asynchronous
   input  wire logic             flash_reset_n,
   // Operation start from command decoder
   input  wire logic             op_start,
   input  wire sfrb_pkg::sfrb_op_t op_kind,
   input  wire logic             read_active,
   input  wire logic             latch_set,
   input  wire logic             latch_clear,
   // Serial data output from shifter
   input  wire logic             so_data,
   input  wire logic             so_drive,
   // Pin side
   output logic                  so_out,
   output logic                  so_oe,
   // Status and state
   output logic                  write_in_progress,
   output logic                  write_enable_latch,
   output logic                  lock_bit,
   output logic                  in_reset,
   output logic                  op_done,
   output logic                  op_aborted,
   output sfrb_pkg::sfrb_intr_t  interrupted
);
   import sfrb_pkg::*;

   // Status byte as delivered; bits picked by position
   localparam logic [7:0] STATUS_RST = `SFRB_STATUS_RST;

   // ------------------------------------------------------------------
   // Pin synchroniser
   // ------------------------------------------------------------------
   logic rst_pin_n_s;

   sfrb_sync #(.WIDTH(1), .INIT(1'b1)) u_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .d       (flash_reset_n),
      .q       (rst_pin_n_s)
   );

   // ------------------------------------------------------------------
   // Reset pulse width measure
   // ------------------------------------------------------------------
   logic [31:0] low_cnt_r;
   logic        low_full;
   logic        pin_low;

   assign pin_low  = !rst_pin_n_s;
   assign low_full = (low_cnt_r >= 32'(RST_PULSE_CYC - 1));

   // Saturating count of consecutive low cycles
   always_ff @(posedge ref_clk) begin
      if (rst || !pin_low) begin
         low_cnt_r <= 32'h0000_0000;
      end else if (!low_full) begin
         low_cnt_r <= low_cnt_r + 32'h0000_0001;
      end
   end

   // ------------------------------------------------------------------
   // Busy duration select
   // ------------------------------------------------------------------
   function automatic logic [47:0] op_cycles(input sfrb_op_t k);
      case (k)
         SFRB_OP_STATUS_WRITE:   op_cycles = 48'(SWC_CYC);   // [RQ11] status write time
         SFRB_OP_PAGE_PROG:      op_cycles = 48'(TPP_CYC);   // [RQ12] page program time
         SFRB_OP_BYTE_PROG:      op_cycles = 48'(TBP_CYC);   // [RQ13] byte program time
         SFRB_OP_SECTOR_ERASE:   op_cycles = 48'(TSE_CYC);   // [RQ14] sector erase time
         SFRB_OP_BLOCK32_ERASE:  op_cycles = 48'(TBE32_CYC); // [RQ15] 32KB erase time
         SFRB_OP_BLOCK64_ERASE:  op_cycles = 48'(TBE64_CYC); // [RQ16] 64KB erase time
         SFRB_OP_CHIP_ERASE:     op_cycles = 48'(TCE_CYC);   // [RQ17] chip erase time
         SFRB_OP_PROT_SELECT:    op_cycles = 48'(TWPS_CYC);  // [RQ18] protection select time
         SFRB_OP_SECURITY_WRITE: op_cycles = 48'(TWSR_CYC);  // [RQ19] security write time
         default:                op_cycles = 48'h0000_0000_0001;
      endcase
   endfunction

   // Map an operation to its interruption class
   function automatic sfrb_intr_t op_class(input sfrb_op_t k);
      case (k)
         SFRB_OP_STATUS_WRITE:                           op_class = SFRB_INT_STATUS_WRITE;
         SFRB_OP_SECTOR_ERASE, SFRB_OP_BLOCK32_ERASE,
         SFRB_OP_BLOCK64_ERASE, SFRB_OP_CHIP_ERASE:      op_class = SFRB_INT_ERASE;
         SFRB_OP_NONE:                                   op_class = SFRB_INT_NONE;
         default:                                        op_class = SFRB_INT_PROGRAM;
      endcase
   endfunction

   // ------------------------------------------------------------------
   // Operation state machine
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {ST_STANDBY, ST_BUSY, ST_RESET} sfrb_state_t;

   sfrb_state_t state_r, state_nxt;
   logic [47:0] busy_cnt_r;
   sfrb_op_t    cur_op_r;
   logic        busy_last;
   logic        start_ok;
   logic        full_reset;

   assign busy_last  = (busy_cnt_r <= 48'h0000_0000_0001);
   assign start_ok   = (state_r == ST_STANDBY) && op_start && (op_kind != SFRB_OP_NONE);
   // A long enough low pulse takes the whole device to reset
   assign full_reset = pin_low && low_full;

   // Next state decode
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_STANDBY: if (start_ok) state_nxt = ST_BUSY;
         ST_BUSY:    if (busy_last) state_nxt = ST_STANDBY;
         ST_RESET:   if (!pin_low) state_nxt = ST_STANDBY;
         default:    state_nxt = ST_STANDBY;
      endcase
      // [RQ1] full reset entry
      if (full_reset) state_nxt = ST_RESET;
   end

   // State, busy counter and interrupted class
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_r     <= ST_STANDBY;
         busy_cnt_r  <= 48'h0000_0000_0000;
         cur_op_r    <= SFRB_OP_NONE;
         interrupted <= SFRB_INT_NONE;
      end else begin
         state_r <= state_nxt;
         if (full_reset) begin
            // [RQ3] abort running operation
            busy_cnt_r <= 48'h0000_0000_0000;
            cur_op_r   <= SFRB_OP_NONE;
            if (state_r == ST_BUSY) begin
               interrupted <= op_class(cur_op_r);
            end else if (state_r == ST_STANDBY) begin
               interrupted <= read_active ? SFRB_INT_READ : SFRB_INT_NONE;
            end
         end else if (start_ok) begin
            busy_cnt_r  <= op_cycles(op_kind);
            cur_op_r    <= op_kind;
            interrupted <= SFRB_INT_NONE;
         end else if (state_r == ST_BUSY) begin
            busy_cnt_r <= busy_cnt_r - 48'h0000_0000_0001;
         end
      end
   end

   // ------------------------------------------------------------------
   // Volatile status bits and pin outputs
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         // [RQ9] status register delivered as zero
         write_in_progress  <= STATUS_RST[`SFRB_STATUS_BUSY_BIT];
         write_enable_latch <= STATUS_RST[`SFRB_STATUS_LATCH_BIT];
         lock_bit           <= 1'b0;
         in_reset           <= 1'b0;
         op_done            <= 1'b0;
         op_aborted         <= 1'b0;
         so_out             <= 1'b0;
         so_oe              <= 1'b0;
      end else begin
         in_reset   <= (state_nxt == ST_RESET);
         op_done    <= (state_r == ST_BUSY) && busy_last && !full_reset;
         op_aborted <= full_reset && (state_r == ST_BUSY);
         if (full_reset || state_r == ST_RESET) begin
            // [RQ2] volatile bits to power-on default
            write_in_progress  <= 1'b0;
            write_enable_latch <= 1'b0;
            lock_bit           <= 1'b0;
         end else begin
            // [RQ21] busy flag spans the operation
            write_in_progress <= (state_nxt == ST_BUSY);
            // Completion of a write clears the latch; set wins
            if (latch_set) begin
               write_enable_latch <= 1'b1;
            end else if (latch_clear || op_done) begin
               write_enable_latch <= 1'b0;
            end
         end
         // [RQ4] output floats while reset is held
         so_oe  <= so_drive && !pin_low && (state_nxt != ST_RESET);
         so_out <= so_data;
      end
   end
endmodule

/* sfrb_chk.sv */
// Assertion checker for the flash reset and busy timer
`timescale 1ns/1ps
module sfrb_chk #(
   parameter int RST_PULSE_CYC = 20,
   parameter int OP_CYC        = 20
) (
   // Clock and reset
   input wire logic                 ref_clk,
   input wire logic                 rst,
   // Watched ports
   input wire logic                 flash_reset_n,
   input wire logic                 op_start,
   input wire sfrb_pkg::sfrb_op_t   op_kind,
   input wire logic                 so_oe,
   input wire logic                 write_in_progress,
   input wire logic                 write_enable_latch,
   input wire logic                 lock_bit,
   input wire logic                 in_reset,
   input wire logic                 op_done,
   input wire logic                 op_aborted,
   input wire sfrb_pkg::sfrb_intr_t interrupted
);
   import sfrb_pkg::*;
   localparam int DONE_DLY = OP_CYC + 1;
   logic [15:0] lo_cnt_r;
   logic        start_acc;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ------------------------------
   // Helpers and properties
   // ------------------------------
   // Accepted start; pin low run length saturates so long holds stay legal
   assign start_acc = op_start && (op_kind != SFRB_OP_NONE) && !write_in_progress && !in_reset;
   always_ff @(posedge ref_clk) begin
      if (rst || flash_reset_n) begin
         lo_cnt_r <= 16'h0000;
      end else if (lo_cnt_r != 16'hFFFF) begin
         lo_cnt_r <= lo_cnt_r + 16'h0001;
      end
   end
   property p_short_rst; lo_cnt_r == RST_PULSE_CYC |-> !in_reset; endproperty
   a_short_rst: assert property (p_short_rst) else $error("reset before pulse width");
   property p_long_rst; lo_cnt_r == RST_PULSE_CYC + 5 |-> in_reset; endproperty
   a_long_rst: assert property (p_long_rst) else $error("no reset after pulse width");
   property p_rst_state; $rose(in_reset) |-> !write_in_progress && !write_enable_latch && !lock_bit; endproperty
   a_rst_state: assert property (p_rst_state) else $error("volatile bits kept");
   property p_release; $rose(flash_reset_n) |-> ##[1:4] !in_reset; endproperty
   a_release: assert property (p_release) else $error("reset held after release");
   property p_abort; $rose(in_reset) && $past(write_in_progress) |-> op_aborted && interrupted != SFRB_INT_NONE;
   endproperty
   a_abort: assert property (p_abort) else $error("op not aborted");
   property p_hiz_rst; in_reset |-> !so_oe; endproperty
   a_hiz_rst: assert property (p_hiz_rst) else $error("output driven in reset");
   property p_hiz_pin; !flash_reset_n [*3] |=> !so_oe; endproperty
   a_hiz_pin: assert property (p_hiz_pin) else $error("output driven with pin low");
   property p_done; start_acc |-> ##DONE_DLY (op_done || interrupted != SFRB_INT_NONE); endproperty
   a_done: assert property (p_done) else $error("op length wrong");
   property p_busy; start_acc |=> (write_in_progress || in_reset) [*8]; endproperty
   a_busy: assert property (p_busy) else $error("busy dropped early");
   property p_done_idle; op_done |-> !write_in_progress; endproperty
   a_done_idle: assert property (p_done_idle) else $error("busy after done");
   c_start: cover property (start_acc);
   c_abort: cover property (op_aborted);
   c_done: cover property (op_done);
endmodule

bind sfrb_core sfrb_chk #(.RST_PULSE_CYC(RST_PULSE_CYC), .OP_CYC(int'(SWC_CYC))) u_chk (
   .ref_clk, .rst, .flash_reset_n, .op_start, .op_kind, .so_oe, .write_in_progress,
   .write_enable_latch, .lock_bit, .in_reset, .op_done, .op_aborted, .interrupted);

/* sfrb_host.sv */
// Host controller model: reset pin, op requests, recovery waits
`timescale 1ns/1ps
module sfrb_host #(
   parameter int PWR_CYC   = 75,
   parameter int RCV_PROG  = 100,
   parameter int RCV_ERASE = 200,
   parameter int RCV_SW    = 20
) (
   // Clock
   input wire logic           ref_clk,
   // Requests to the device
   output logic               flash_reset_n,
   output logic               op_start,
   output sfrb_pkg::sfrb_op_t op_kind,
   output logic               read_active,
   output logic               latch_set,
   output logic               latch_clear,
   // Power-up done
   output logic               up
);
   import sfrb_pkg::*;
   // 200 ns at a 4 ns clock
   localparam int RCV_READ = 50;
   // serial clock ceiling set by dummy count
   localparam int DUMMY_CYC    = 6;
   localparam int SCLK_MAX_MHZ = (DUMMY_CYC == 4) ? 54 : 70;
   // ------------------------------
   // Driver
   // ------------------------------
   // deselected until delay
   initial begin
      flash_reset_n = 1'b1;
      op_start      = 1'b0;
      op_kind       = SFRB_OP_NONE;
      read_active   = 1'b0;
      latch_set     = 1'b0;
      latch_clear   = 1'b0;
      up            = 1'b0;
      repeat (PWR_CYC) @(negedge ref_clk);
      up = 1'b1;
   end
   // Latch write enable, then one start pulse
   task automatic start(input sfrb_op_t k);
      latch_set = 1'b1;
      @(negedge ref_clk);
      latch_set = 1'b0;
      op_start = 1'b1;
      op_kind  = k;
      @(negedge ref_clk);
      op_start = 1'b0;
      op_kind  = SFRB_OP_NONE;
   endtask
   task automatic pin_low(input logic rd);
      read_active   = rd;
      flash_reset_n = 1'b0;
   endtask
   task automatic pin_release(input sfrb_intr_t cls);
      flash_reset_n = 1'b1;
      read_active   = 1'b0;
      case (cls)
         SFRB_INT_READ:         repeat (RCV_READ) @(negedge ref_clk);
         SFRB_INT_PROGRAM:      repeat (RCV_PROG) @(negedge ref_clk);
         SFRB_INT_ERASE:        repeat (RCV_ERASE) @(negedge ref_clk);
         SFRB_INT_STATUS_WRITE: repeat (RCV_SW) @(negedge ref_clk);
         default:               @(negedge ref_clk);
      endcase
   endtask
endmodule

/* tb_top.sv */
// Self-checking testbench for the flash reset and busy timer
`timescale 1ns/1ps
module tb_top;
   import sfrb_pkg::*;
   // Ops outlast a qualified pulse, so aborts land mid-op
   localparam int N  = 40;
   localparam int RP = 20;
   logic       ref_clk, rst, so_data, so_drive, up;
   logic       flash_reset_n, op_start, read_active, latch_set, latch_clear;
   sfrb_op_t   op_kind;
   logic       so_out, so_oe, write_in_progress, write_enable_latch, lock_bit;
   logic       in_reset, op_done, op_aborted;
   sfrb_intr_t interrupted;
   int         errors, cmp_count, cyc, k;
   // ------------------------------
   // Clock, model, design
   // ------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   sfrb_host #(.RCV_SW(N)) u_host (.ref_clk, .flash_reset_n, .op_start, .op_kind, .read_active, .latch_set,
      .latch_clear, .up);
   sfrb_core #(.RST_PULSE_CYC(RP), .SWC_CYC(N), .TPP_CYC(N), .TBP_CYC(N), .TSE_CYC(N), .TBE32_CYC(N),
      .TBE64_CYC(N), .TCE_CYC(N), .TWPS_CYC(N), .TWSR_CYC(N)) uut (.ref_clk, .rst, .flash_reset_n,
      .op_start, .op_kind, .read_active, .latch_set, .latch_clear, .so_data, .so_drive, .so_out, .so_oe,
      .write_in_progress, .write_enable_latch, .lock_bit, .in_reset, .op_done, .op_aborted, .interrupted);
   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("Comparisons %0d, errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Negedges from start to done, bounded
   task automatic wait_done(output int n);
      n = 1;
      while (op_done !== 1'b1 && n < 200) begin
         check(write_in_progress, 8'h01);
         @(negedge ref_clk);
         n++;
      end
   endtask
   task automatic t_reset_state;
      check({write_in_progress, write_enable_latch, lock_bit, in_reset, so_oe}, 8'h00);
      check(interrupted, SFRB_INT_NONE);
   endtask
   task automatic t_ops;
      for (int i = 1; i <= 9; i++) begin
         u_host.start(sfrb_op_t'(i));
         wait_done(k);
         check(8'(k), 8'(N + 1));
         @(negedge ref_clk);
         check({write_in_progress, write_enable_latch}, 8'h00);
         @(negedge ref_clk);
      end
   endtask
   // pin reset cuts an op or a read
   task automatic t_abort(input sfrb_op_t kind, input sfrb_intr_t cls);
      logic ab;
      ab       = 1'b0;
      so_drive = 1'b1;
      if (kind != SFRB_OP_NONE) u_host.start(kind);
      repeat (3) @(negedge ref_clk);
      check({so_oe, so_out}, 8'h03);
      u_host.pin_low(cls == SFRB_INT_READ);
      repeat (RP + 6) begin
         @(negedge ref_clk);
         ab = ab | op_aborted;
      end
      check({in_reset, so_oe, write_in_progress, ab}, 8'h08 | 8'(kind != SFRB_OP_NONE));
      so_drive = 1'b0;
      u_host.pin_release(cls);
      check({write_in_progress, write_enable_latch, in_reset}, 8'h00);
      check(interrupted, cls);
   endtask
   task automatic t_short;
      u_host.start(SFRB_OP_PAGE_PROG);
      u_host.pin_low(1'b0);
      repeat (RP - 8) @(negedge ref_clk);
      u_host.pin_release(SFRB_INT_NONE);
      wait_done(k);
      check({op_done, in_reset, interrupted}, 8'h10);
   endtask
   // ------------------------------
   // Sequence and hang guard
   // ------------------------------
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         final_report();
      end
   end
   initial begin
      rst      = 1'b1;
      so_data  = 1'b1;
      so_drive = 1'b0;
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
      wait (up === 1'b1);
      @(negedge ref_clk);
      t_reset_state();
      t_ops();
      t_abort(SFRB_OP_PAGE_PROG, SFRB_INT_PROGRAM);
      t_abort(SFRB_OP_CHIP_ERASE, SFRB_INT_ERASE);
      t_abort(SFRB_OP_STATUS_WRITE, SFRB_INT_STATUS_WRITE);
      t_abort(SFRB_OP_NONE, SFRB_INT_READ);
      t_short();
      final_report();
   end
endmodule
